/* sslp_pkg.sv */
// Shared constants and types for the sync SRAM sleep and control block.
package sslp_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 32;
	localparam int BYTES = 4;
	// Clock period and the sleep timing figures in nanoseconds, with the cycle counts derived from them.
	localparam int CLK_PERIOD_NS = 4;
	localparam int SLEEP_ENTRY_NS = 2 * CLK_PERIOD_NS;
	localparam int SLEEP_RECOVERY_TIME_NS = 2 * CLK_PERIOD_NS;
	localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS / CLK_PERIOD_NS < 1) ? 1 : SLEEP_ENTRY_NS / CLK_PERIOD_NS;
	localparam int SLEEP_RECOVERY_CYC = ((SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
		(SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] SLEEP_CNT_RESET = 2'h0;
	typedef enum logic [1:0] {
		SSLP_AWAKE = 2'b00,
		SSLP_ENTER = 2'b01,
		SSLP_ASLEEP = 2'b10,
		SSLP_RECOVER = 2'b11
	} sslp_state_t;
endpackage : sslp_pkg

/* sslp_if.sv */
// Pin-level link between the SRAM controller and the SRAM device.
`timescale 1ns/1ps
`default_nettype none
interface sslp_if;
	logic [sslp_pkg::ADDR_W-1:0] addr;
	logic processor_addr_strobe_n;
	logic controller_addr_strobe_n;
	logic burst_step_n;
	logic chip_select_one_n;
	logic chip_select_two;
	logic chip_select_three_n;
	logic write_enable_strobe_n;
	logic global_write_strobe_n;
	logic [sslp_pkg::BYTES-1:0] byte_write_strobe_n;
	logic output_enable_n;
	logic sleep_request;
	logic linear_order_select_n;
	logic [sslp_pkg::DATA_W-1:0] dq_ctl_o;
	logic dq_ctl_oe;
	logic [sslp_pkg::DATA_W-1:0] dq_mem_o;
	logic dq_mem_oe;
	logic [sslp_pkg::DATA_W-1:0] dq_ctl_i;
	logic [sslp_pkg::DATA_W-1:0] dq_mem_i;
	// Resolved data bus; either end's input is whoever drives.
	assign dq_ctl_i = dq_mem_oe ? dq_mem_o : dq_ctl_o;
	assign dq_mem_i = dq_ctl_oe ? dq_ctl_o : dq_mem_o;
	modport mem (input addr, processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n,
		chip_select_one_n, chip_select_two, chip_select_three_n, write_enable_strobe_n,
		global_write_strobe_n, byte_write_strobe_n, output_enable_n, sleep_request,
		linear_order_select_n, dq_mem_i, output dq_mem_o, dq_mem_oe);
	modport ctl (output addr, processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n,
		chip_select_one_n, chip_select_two, chip_select_three_n, write_enable_strobe_n,
		global_write_strobe_n, byte_write_strobe_n, output_enable_n, sleep_request,
		linear_order_select_n, dq_ctl_o, dq_ctl_oe, input dq_ctl_i);
endinterface : sslp_if
`default_nettype wire

/* sslp_ctl.sv */
// Controller end: non-burst single-word access sequencer with sleep handling.
`timescale 1ns/1ps
`default_nettype none
module sslp_ctl (
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	input wire logic REQ_I,
	input wire logic WRITE_I,
	input wire logic [sslp_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [sslp_pkg::DATA_W-1:0] WDATA_I,
	input wire logic [sslp_pkg::BYTES-1:0] BYTE_EN_I,
	input wire logic SLEEP_I,
	output logic READY_O,
	output logic RVALID_O,
	output logic [sslp_pkg::DATA_W-1:0] RDATA_O,
	sslp_if.ctl PIN
);
	logic sleep_req;
	logic [1:0] quiet_cnt;
	logic [3:0] rd_pipe;
	logic take;
	// Quiet window: two idle cycles after sleep is raised and while it recovers.
	assign take = REQ_I && READY_O;
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			sleep_req <= 1'b0;
			quiet_cnt <= sslp_pkg::SLEEP_CNT_RESET;
		end else begin
			if (SLEEP_I && !take && quiet_cnt == 2'(sslp_pkg::SLEEP_ENTRY_CYC)) begin
				sleep_req <= 1'b1; // R7
			end else if (!SLEEP_I) begin
				sleep_req <= 1'b0;
			end
			if (SLEEP_I != sleep_req || (!SLEEP_I && sleep_req)) begin
				quiet_cnt <= (quiet_cnt == 2'(sslp_pkg::SLEEP_ENTRY_CYC)) ? quiet_cnt : quiet_cnt + 2'h1;
			end else if (sleep_req) begin
				quiet_cnt <= sslp_pkg::SLEEP_CNT_RESET;
			end else if (quiet_cnt != sslp_pkg::SLEEP_CNT_RESET) begin
				quiet_cnt <= quiet_cnt - 2'h1; // R6
			end
		end
	end
	// Ready only when awake, not winding down and not recovering.
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			READY_O <= 1'b0;
		end else begin
			// A read in flight holds ready low, so a write never meets returning read data on the bus.
			READY_O <= !SLEEP_I && !sleep_req && quiet_cnt == sslp_pkg::SLEEP_CNT_RESET && !take &&
				rd_pipe[2:0] == 3'h0; // R8
		end
	end
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			PIN.addr <= '0;
			PIN.controller_addr_strobe_n <= 1'b1;
			PIN.write_enable_strobe_n <= 1'b1;
			PIN.byte_write_strobe_n <= '1;
			PIN.output_enable_n <= 1'b1;
			PIN.dq_ctl_o <= '0;
			PIN.dq_ctl_oe <= 1'b0;
			rd_pipe <= 4'h0;
		end else begin
			PIN.controller_addr_strobe_n <= !take; // R14
			PIN.write_enable_strobe_n <= !(take && WRITE_I);
			PIN.byte_write_strobe_n <= (take && WRITE_I) ? ~BYTE_EN_I : '1;
			PIN.dq_ctl_oe <= take && WRITE_I;
			if (take) begin
				PIN.addr <= ADDR_I;
				PIN.dq_ctl_o <= WDATA_I;
			end
			// Output enable drops before a write starts, so the buses never fight.
			PIN.output_enable_n <= !(take && !WRITE_I) && !(rd_pipe[0] || rd_pipe[1]); // R4
			rd_pipe <= {rd_pipe[2:0], take && !WRITE_I};
		end
	end
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			RVALID_O <= 1'b0;
			RDATA_O <= '0;
		end else begin
			RVALID_O <= rd_pipe[3];
			if (rd_pipe[3]) begin
				RDATA_O <= PIN.dq_ctl_i;
			end
		end
	end
	// Fixed ties for non-burst use; burst order is tied to a firm level.
	assign PIN.processor_addr_strobe_n = 1'b1; // R14
	assign PIN.burst_step_n = 1'b1;
	assign PIN.chip_select_one_n = 1'b0;
	assign PIN.chip_select_two = 1'b1;
	assign PIN.chip_select_three_n = 1'b0;
	assign PIN.global_write_strobe_n = 1'b1;
	assign PIN.linear_order_select_n = 1'b1; // R15
	assign PIN.sleep_request = sleep_req; // R7
endmodule : sslp_ctl
`default_nettype wire

/* sslp_mem.sv */
// Device end: synchronous pipelined SRAM control decode, sleep and array.
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: Write when enable and byte, or global.
// R2: Enabled only with selects valid at strobe.
// R3: Output enable ignored once write begins.
// R4: Controller drops output enable before writes.
// R5: Sleep request forces lowest-power state.
// R6: Controller keeps timing around sleep.
// R7: No new cycles two clocks before sleep.
// R8: Strobes stay high before and after sleep.
// R9: Blackout writes may corrupt the array.
// R10: Read data invalid after sleep raised.
// R11: Entering sleep deselects the device.
// R12: Internal clock gated while asleep.
// R13: Asleep means no reads or writes.
// R14: Non-burst ties accept address every clock.
// R15: Burst order pin tied firm, no effect.
// R16: Resume decoding after recovery, contents kept.
module sslp_mem #(
	parameter int DEPTH = 1 << sslp_pkg::ADDR_W
) (
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	output logic ASLEEP_O,
	output logic BLACKOUT_O,
	sslp_if.mem PIN
);
	sslp_pkg::sslp_state_t state;
	logic [1:0] cnt;
	logic [sslp_pkg::DATA_W-1:0] wr_data;
	wire [sslp_pkg::DATA_W-1:0] lane_rd;
	logic [sslp_pkg::ADDR_W-1:0] burst_addr;
	logic [1:0] burst_ofs;
	logic selected;
	logic rd_stage;
	logic rd_out;
	logic wr_pend;
	logic [sslp_pkg::BYTES-1:0] wr_bytes;
	logic [sslp_pkg::ADDR_W-1:0] wr_addr;
	logic [sslp_pkg::DATA_W-1:0] rd_data;
	logic any_strobe;
	logic is_write;
	logic enabled;
	logic clk_gate;
	logic [sslp_pkg::ADDR_W-1:0] cur_addr;
	assign any_strobe = !PIN.processor_addr_strobe_n || !PIN.controller_addr_strobe_n;
	// Processor strobe write is never taken in the same cycle, as the strobe has priority.
	assign is_write = !PIN.global_write_strobe_n ||
		(!PIN.write_enable_strobe_n && !(&PIN.byte_write_strobe_n)); // R1
	assign enabled = !PIN.chip_select_one_n && PIN.chip_select_two && !PIN.chip_select_three_n; // R2
	// Internal clock qualifier; while it is low decode and read path sit in reset and the array holds, but the sleep state machine runs.
	assign clk_gate = state != sslp_pkg::SSLP_ASLEEP; // R12
	assign cur_addr = PIN.linear_order_select_n ?
		{burst_addr[sslp_pkg::ADDR_W-1:2], burst_addr[1:0] ^ burst_ofs} :
		{burst_addr[sslp_pkg::ADDR_W-1:2], burst_addr[1:0] + burst_ofs};
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			state <= sslp_pkg::SSLP_AWAKE;
			cnt <= sslp_pkg::SLEEP_CNT_RESET;
		end else begin
			case (state)
				sslp_pkg::SSLP_AWAKE: begin
					if (PIN.sleep_request) begin
						state <= sslp_pkg::SSLP_ENTER; // R5
						cnt <= 2'(sslp_pkg::SLEEP_ENTRY_CYC - 1);
					end
				end
				sslp_pkg::SSLP_ENTER: begin
					if (!PIN.sleep_request) begin
						state <= sslp_pkg::SSLP_AWAKE;
					end else if (cnt == 2'h0) begin
						state <= sslp_pkg::SSLP_ASLEEP; // R5
					end else begin
						cnt <= cnt - 2'h1;
					end
				end
				sslp_pkg::SSLP_ASLEEP: begin
					if (!PIN.sleep_request) begin
						state <= sslp_pkg::SSLP_RECOVER;
						cnt <= 2'(sslp_pkg::SLEEP_RECOVERY_CYC - 1);
					end
				end
				sslp_pkg::SSLP_RECOVER: begin
					if (PIN.sleep_request) begin
						state <= sslp_pkg::SSLP_ENTER;
						cnt <= 2'(sslp_pkg::SLEEP_ENTRY_CYC - 1);
					end else if (cnt == 2'h0) begin
						state <= sslp_pkg::SSLP_AWAKE; // R16
					end else begin
						cnt <= cnt - 2'h1;
					end
				end
				default: begin
					state <= sslp_pkg::SSLP_AWAKE;
				end
			endcase
		end
	end
	// Cycle decode. Strobes in the blackout are still decoded; the array is not protected then.
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I || !clk_gate) begin
			selected <= 1'b0; // R11
			burst_addr <= '0;
			burst_ofs <= 2'h0;
			wr_pend <= 1'b0;
			wr_bytes <= '0;
			wr_addr <= '0;
			wr_data <= '0;
			rd_stage <= 1'b0;
		end else begin
			if (any_strobe) begin
				selected <= enabled; // R2
				burst_addr <= PIN.addr; // R14
				burst_ofs <= 2'h0;
			end else if (!PIN.burst_step_n && selected) begin
				burst_ofs <= burst_ofs + 2'h1;
			end
			// A processor-strobe cycle never writes; its write, if any, comes on the next clock.
			wr_pend <= any_strobe ? enabled && is_write && PIN.processor_addr_strobe_n :
				selected && is_write; // R9
			wr_bytes <= PIN.global_write_strobe_n ? ~PIN.byte_write_strobe_n : '1;
			wr_addr <= any_strobe ? PIN.addr : cur_addr;
			wr_data <= PIN.dq_mem_i;
			rd_stage <= any_strobe ? enabled && (!is_write || !PIN.processor_addr_strobe_n) :
				selected && !PIN.burst_step_n && !is_write;
		end
	end
	// Write data is registered with the address, as the controller drives it for one cycle only.
	// Each byte lane owns its array, so no two processes write the same variable.
	for (genvar b = 0; b < sslp_pkg::BYTES; b++) begin : g_byte
		logic [7:0] lane [DEPTH];
		always_ff @(posedge CLOCK_I) begin
			if (clk_gate && wr_pend && wr_bytes[b]) begin
				lane[wr_addr] <= wr_data[8*b +: 8];
			end
		end
		assign lane_rd[8*b +: 8] = lane[wr_addr];
	end
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I || !clk_gate) begin
			rd_out <= 1'b0; // R13
			rd_data <= '0;
		end else begin
			rd_out <= rd_stage;
			if (rd_stage) begin
				rd_data <= lane_rd; // R10
			end
		end
	end
	// Output drive follows output enable for reads only; any write cuts the driver.
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			PIN.dq_mem_o <= '0;
			PIN.dq_mem_oe <= 1'b0;
		end else begin
			PIN.dq_mem_o <= rd_data;
			PIN.dq_mem_oe <= rd_out && !PIN.output_enable_n && !wr_pend && clk_gate; // R3
		end
	end
	always_ff @(posedge CLOCK_I) begin
		if (!RSTN_I) begin
			ASLEEP_O <= 1'b0;
			BLACKOUT_O <= 1'b0;
		end else begin
			ASLEEP_O <= state == sslp_pkg::SSLP_ASLEEP;
			BLACKOUT_O <= state == sslp_pkg::SSLP_ENTER || state == sslp_pkg::SSLP_RECOVER;
		end
	end
endmodule : sslp_mem
`default_nettype wire

/* sslp_chk.sv */
// Pin checker for the controller-to-device link.
`timescale 1ns/1ps
`default_nettype none
module sslp_chk (
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_step_n,
	input wire logic chip_select_one_n,
	input wire logic chip_select_two,
	input wire logic write_enable_strobe_n,
	input wire logic global_write_strobe_n,
	input wire logic [sslp_pkg::BYTES-1:0] byte_write_strobe_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic linear_order_select_n,
	input wire logic dq_ctl_oe,
	input wire logic dq_mem_oe
);
	logic wr;
	logic rd;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I);
	// All bytes masked with the enable low is a read, not a write.
	assign wr = !global_write_strobe_n || (!write_enable_strobe_n && byte_write_strobe_n != 4'hf);
	assign rd = !controller_addr_strobe_n && !wr;
	sequence s_idle;
		controller_addr_strobe_n && processor_addr_strobe_n && write_enable_strobe_n && global_write_strobe_n;
	endsequence
	sequence s_wr;
		!controller_addr_strobe_n && wr;
	endsequence
	AST_READ_DRIVE: assert property (rd ##2 !output_enable_n |=> dq_mem_oe)
		else $error("read not driven");
	AST_DRIVE_CAUSE: assert property (dq_mem_oe |-> $past(rd, 3))
		else $error("drive without a read");
	AST_WRITE_HIZ: assert property (s_wr |=> !dq_mem_oe ##1 !dq_mem_oe)
		else $error("device drove during write");
	AST_WRITE_OE: assert property (s_wr |-> output_enable_n && dq_ctl_oe)
		else $error("write without bus turned");
	AST_SLEEP_QUIET: assert property (sleep_request [*3] |-> !dq_mem_oe)
		else $error("device drove while asleep");
	AST_SLEEP_IDLE: assert property (sleep_request |-> s_idle)
		else $error("strobe during sleep");
	AST_PRE_SLEEP: assert property ($rose(sleep_request) |-> $past(controller_addr_strobe_n, 2))
		else $error("sleep raised too soon");
	AST_RECOVER_IDLE: assert property ($fell(sleep_request) |-> s_idle ##1 s_idle)
		else $error("strobe during recovery");
	AST_TIES: assert property (processor_addr_strobe_n && burst_step_n && !chip_select_one_n && chip_select_two
		&& $stable(linear_order_select_n))
		else $error("non-burst ties broken");
endmodule : sslp_chk
`default_nettype wire

/* tb_top.sv */
// Bench joining the controller and device ends over the pin link.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic CLOCK_I, RSTN_I, req, wr, sleep, ready, rvalid, asleep, blackout;
	logic [sslp_pkg::ADDR_W-1:0] addr;
	logic [sslp_pkg::DATA_W-1:0] wdata, rdata, exp;
	logic [sslp_pkg::BYTES-1:0] be;
	int err_count, n_compared, cyc;
	sslp_if pin ();
	sslp_ctl u_sslp_ctl (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .REQ_I(req), .WRITE_I(wr), .ADDR_I(addr),
		.WDATA_I(wdata), .BYTE_EN_I(be), .SLEEP_I(sleep), .READY_O(ready), .RVALID_O(rvalid), .RDATA_O(rdata),
		.PIN(pin.ctl));
	sslp_mem u_sslp_mem (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .ASLEEP_O(asleep), .BLACKOUT_O(blackout),
		.PIN(pin.mem));
	sslp_chk u_sslp_chk (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I),
		.processor_addr_strobe_n(pin.processor_addr_strobe_n), .controller_addr_strobe_n(pin.controller_addr_strobe_n),
		.burst_step_n(pin.burst_step_n), .chip_select_one_n(pin.chip_select_one_n),
		.chip_select_two(pin.chip_select_two), .write_enable_strobe_n(pin.write_enable_strobe_n),
		.global_write_strobe_n(pin.global_write_strobe_n), .byte_write_strobe_n(pin.byte_write_strobe_n),
		.output_enable_n(pin.output_enable_n), .sleep_request(pin.sleep_request),
		.linear_order_select_n(pin.linear_order_select_n), .dq_ctl_oe(pin.dq_ctl_oe), .dq_mem_oe(pin.dq_mem_oe));
	task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
		n_compared++;
		if (got !== want) begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask : check
	task automatic wait_ready();
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 40) begin
			@(posedge CLOCK_I);
			#1;
			n++;
		end
		check(32'(n < 40), 32'h1, "ready");
	endtask : wait_ready
	// Request is held from just after one edge until the edge that samples ready high.
	task automatic issue(input logic w, input logic [16:0] a, input logic [31:0] d, input logic [3:0] b);
		req = 1'b1;
		wr = w;
		addr = a;
		wdata = d;
		be = b;
		wait_ready();
		@(posedge CLOCK_I);
		#1;
		req = 1'b0;
		// An edge passes before the next request, so req never flips twice in one step.
		@(posedge CLOCK_I);
		#1;
	endtask : issue
	task automatic rd_chk(input logic [16:0] a, input logic [31:0] want);
		int n;
		issue(1'b0, a, 32'h0, 4'h0);
		n = 0;
		while (rvalid !== 1'b1 && n < 8) begin
			@(posedge CLOCK_I);
			#1;
			n++;
		end
		check(32'(n), 32'h3, "read latency");
		check(rdata, want, "read data");
	endtask : rd_chk
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	initial begin
		CLOCK_I = 1'b0;
		forever #2 CLOCK_I = ~CLOCK_I;
	end
	always @(posedge CLOCK_I) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			$display("unexpected at %0t: run hung", $time);
			give_verdict();
		end
	end
	initial begin
		{RSTN_I, req, wr, sleep, addr, wdata, be} = '0;
		repeat (5) @(posedge CLOCK_I);
		#1;
		RSTN_I = 1'b1;
		// Two writes an idle clock apart, including the top address, then read back.
		issue(1'b1, 17'h00000, 32'h1234abcd, 4'hf);
		issue(1'b1, 17'h1ffff, 32'hcafef00d, 4'hf);
		rd_chk(17'h00000, 32'h1234abcd);
		rd_chk(17'h1ffff, 32'hcafef00d);
		$display("test words done");
		issue(1'b1, 17'h00005, 32'h0, 4'hf);
		exp = 32'h0;
		for (int b = 0; b < 4; b++) begin
			issue(1'b1, 17'h00005, 32'ha5a5a5a5, 4'(1 << b));
			exp[b*8 +: 8] = 8'ha5;
			rd_chk(17'h00005, exp);
		end
		// No byte selected must leave the word untouched.
		issue(1'b1, 17'h00005, 32'h0, 4'h0);
		rd_chk(17'h00005, exp);
		$display("test bytes done");
		sleep = 1'b1;
		repeat (6) @(posedge CLOCK_I);
		#1;
		check(32'(blackout), 32'h1, "blackout on entry");
		check(32'(asleep), 32'h0, "asleep too early");
		repeat (6) @(posedge CLOCK_I);
		#1;
		check(32'(asleep), 32'h1, "asleep");
		check(32'(blackout), 32'h0, "blackout in sleep");
		check(32'(ready), 32'h0, "ready in sleep");
		sleep = 1'b0;
		wait_ready();
		check(32'(blackout), 32'h1, "blackout in recovery");
		rd_chk(17'h00005, exp);
		rd_chk(17'h1ffff, 32'hcafef00d);
		$display("test sleep done");
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
